// ---- aac_defs.vh ----
/*
  Constants for the averaging and compare logic of the converter:
  conversion timing in conversion-clock and bus-clock cycles,
  averaging encodings, widths and reset values.
  Assumes it is included by bare name from the design files.
*/
`ifndef AAC_DEFS_VH
`define AAC_DEFS_VH

// bus clock rate and conversion clock divider
`define AAC_BUS_CLK_MHZ        100
`define AAC_CONV_DIV           3'h2
`define AAC_DIV_W              3

// first-conversion overhead
`define AAC_OVH_SHORT_CONVERSION_CLOCK     6'h05
`define AAC_OVH_LONG_CONVERSION_CLOCK      6'h03
`define AAC_OVH_BUS            6'h05

// per-conversion durations in conversion-clock cycles
`define AAC_BASE_8BIT          6'h11
`define AAC_BASE_10BIT         6'h14
`define AAC_HS_ADDER           6'h02
`define AAC_LST_00             6'h14
`define AAC_LST_01             6'h0C
`define AAC_LST_10             6'h06
`define AAC_LST_11             6'h02

// averaging: log2 of the count, per select code
`define AAC_AVG_SEL_4          2'h0
`define AAC_AVG_SEL_8          2'h1
`define AAC_AVG_SEL_16         2'h2
`define AAC_AVG_SEL_32         2'h3
`define AAC_SHIFT_1            3'h0
`define AAC_SHIFT_4            3'h2
`define AAC_SHIFT_8            3'h3
`define AAC_SHIFT_16           3'h4
`define AAC_SHIFT_32           3'h5

// widths
`define AAC_DATA_W             10
`define AAC_ACC_W              15

// reset values
`define AAC_RESULT_RESET       10'h000
`define AAC_ACC_RESET          15'h0000

`endif

// ---- aac_compare.v ----
/*
  Compare unit: judges one (possibly averaged) result against one
  or two compare values in the six documented compare modes.
  Purely combinational; the caller registers whatever it drives out.
*/
`timescale 1ns/10ps
`default_nettype none

module aac_compare (
  // value under test
  input  wire [9:0] value,
  // compare setup
  input  wire [9:0] first_compare_value,
  input  wire [9:0] second_compare_value,
  input  wire       compare_greater_select,
  input  wire       compare_range_enable,
  // verdict
  output reg        compare_true
);

  wire below_first  = value <  first_compare_value;
  wire at_or_above1 = value >= first_compare_value;
  wire above_second = value >  second_compare_value;
  wire at_or_below2 = value <= second_compare_value;
  wire first_le_sec = first_compare_value <= second_compare_value;

  always @* begin
    case ({compare_range_enable, compare_greater_select})
      2'h0: compare_true = below_first;
      2'h1: compare_true = at_or_above1;
      2'h2: compare_true = first_le_sec ? (below_first | above_second)
                                        : (below_first & above_second);
      2'h3: compare_true = first_le_sec ? (at_or_above1 & at_or_below2)
                                        : (at_or_above1 | at_or_below2);
      default: compare_true = 1'b0;
    endcase
  end

endmodule // aac_compare

`default_nettype wire

// ---- aac_average_compare.v ----
/*
  Result post-processing and timing of a successive-approximation
  converter: sequences single or averaged conversions, accumulates
  and averages samples, applies the compare and posts the result.
  Assumes sample_value is valid from the converter core, on clk, at
  the end of every conversion, and that control inputs come from
  registers on the same clock.
*/
// How it works
// - averaging enable makes the block average 4, 8, 16 or 32 conversions
// - active flag stays high for the whole averaging sequence
// - each sample is accumulated; average formed only after the last one
// - single conversions inside an averaging run never set complete flag
// - average posted and complete flag set only when compare off or true
// - interrupt request follows complete flag while interrupt enable is 1
// - averaging continues in wait and stop; interrupt wakes the MCU
// - single threshold, greater select clear: true when result below first value
// - single threshold, greater select set: true when result at or above first
// - range, greater clear, first <= second: outside range, endpoints excluded
// - range, greater clear, first > second: inside range, endpoints excluded
// - range, greater set, first <= second: inside range, endpoints included
// - range, greater set, first > second: outside range, endpoints included
// - false compare leaves complete flag clear and result unchanged
// - with averaging, compare judges the averaged value only
// - compare keeps running in wait and stop; a match wakes the MCU while interrupt enable is 1
// - short sample first conversion costs 5 conversion plus 5 bus cycles
// - base conversion is 17 cycles in 8-bit, 20 in 10-bit mode
// - count select 00/01/10/11 means 4/8/16/32; factor 1 when averaging off
// - total time: overhead plus factor times base, long and high-speed adders
// - high-speed configuration adds two conversion cycles to every conversion
`timescale 1ns/10ps
`default_nettype none
`include "aac_defs.vh"

module aac_average_compare (
  // clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // conversion setup
  input  wire       conv_start,
  input  wire       mode_10bit,
  input  wire       long_sample_enable,
  input  wire [1:0] long_sample_select,
  input  wire       high_speed_config,
  // averaging setup
  input  wire       average_enable,
  input  wire [1:0] average_count_select,
  // compare setup
  input  wire       compare_enable,
  input  wire       compare_greater_select,
  input  wire       compare_range_enable,
  input  wire [9:0] first_compare_value,
  input  wire [9:0] second_compare_value,
  // flag handling and power state
  input  wire       complete_irq_enable,
  input  wire       complete_flag_clear,
  input  wire       mcu_low_power,
  // converter core data
  input  wire [9:0] sample_value,
  // status and result
  output reg        conversion_active_flag,
  output reg        conversion_complete_flag,
  output reg  [9:0] result_register,
  output reg        sample_strobe,
  output reg        irq_request,
  output reg        wake_request
);

  localparam [2:0] ST_IDLE     = 3'h0;
  localparam [2:0] ST_OVH_CONVERSION_CLOCK = 3'h1;
  localparam [2:0] ST_OVH_BUS  = 3'h2;
  localparam [2:0] ST_CONVERT  = 3'h3;
  localparam [2:0] ST_FINISH   = 3'h4;

  // log2 of the averaging factor
  function [2:0] avg_shift;
    input       enable;
    input [1:0] sel;
    begin
      if (!enable) begin
        avg_shift = `AAC_SHIFT_1;
      end else begin
        case (sel)
          `AAC_AVG_SEL_4:  avg_shift = `AAC_SHIFT_4;
          `AAC_AVG_SEL_8:  avg_shift = `AAC_SHIFT_8;
          `AAC_AVG_SEL_16: avg_shift = `AAC_SHIFT_16;
          default:         avg_shift = `AAC_SHIFT_32;
        endcase
      end
    end
  endfunction

  // long sample time adder in conversion-clock cycles
  function [5:0] long_adder;
    input       enable;
    input [1:0] sel;
    begin
      if (!enable) begin
        long_adder = 6'h00;
      end else begin
        case (sel)
          2'h0:    long_adder = `AAC_LST_00;
          2'h1:    long_adder = `AAC_LST_01;
          2'h2:    long_adder = `AAC_LST_10;
          default: long_adder = `AAC_LST_11;
        endcase
      end
    end
  endfunction

  // first-conversion overhead in conversion-clock cycles
  function [5:0] first_overhead;
    input long_enable;
    begin
      if (long_enable) begin
        first_overhead = `AAC_OVH_LONG_CONVERSION_CLOCK;
      end else begin
        first_overhead = `AAC_OVH_SHORT_CONVERSION_CLOCK;
      end
    end
  endfunction

  reg  [2:0]              state;
  reg  [`AAC_DIV_W-1:0]   div_cnt;
  reg  [5:0]              phase_cnt;
  reg  [5:0]              conv_left;
  reg  [5:0]              cfg_per_conv;
  reg  [5:0]              cfg_ovh_conversion_clock;
  reg  [2:0]              cfg_shift;
  reg                     cfg_mode_10bit;
  reg  [`AAC_ACC_W-1:0]   acc;

  wire                    conversion_clock_tick;
  wire [`AAC_DATA_W-1:0]  sample_in;
  wire [`AAC_ACC_W-1:0]   acc_shifted;
  wire [`AAC_DATA_W-1:0]  avg_value;
  wire                    cmp_true;
  wire                    post_result;
  wire                    next_complete;
  wire                    next_active;
  wire [5:0]              base_time;
  wire [5:0]              hs_time;
  wire [5:0]              factor;

  // the conversion clock is a tick every AAC_CONV_DIV bus cycles
  assign conversion_clock_tick = (div_cnt == (`AAC_CONV_DIV - 3'h1));

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt <= {`AAC_DIV_W{1'b0}};
    end else if (conversion_clock_tick) begin
      div_cnt <= {`AAC_DIV_W{1'b0}};
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  assign base_time = mode_10bit ? `AAC_BASE_10BIT : `AAC_BASE_8BIT;
  assign hs_time   = high_speed_config ? `AAC_HS_ADDER : 6'h00;
  assign factor    = 6'h01 << avg_shift(average_enable, average_count_select);

  // 8-bit mode keeps only the low byte of the core's word
  assign sample_in = cfg_mode_10bit ? sample_value : {2'h0, sample_value[7:0]};

  assign acc_shifted = acc >> cfg_shift;
  assign avg_value   = acc_shifted[`AAC_DATA_W-1:0];

  aac_compare u_compare (
    .value                  (avg_value),
    .first_compare_value    (first_compare_value),
    .second_compare_value   (second_compare_value),
    .compare_greater_select (compare_greater_select),
    .compare_range_enable   (compare_range_enable),
    .compare_true           (cmp_true)
  );

  assign post_result = (state == ST_FINISH) & (~compare_enable | cmp_true);

  // set wins over a clear in the same cycle
  assign next_complete = post_result | (conversion_complete_flag & ~complete_flag_clear);

  // sequencer: overhead, then factor conversions, then finish
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state          <= ST_IDLE;
      phase_cnt      <= 6'h00;
      conv_left      <= 6'h00;
      cfg_per_conv   <= 6'h00;
      cfg_ovh_conversion_clock   <= 6'h00;
      cfg_shift      <= `AAC_SHIFT_1;
      cfg_mode_10bit <= 1'b0;
      acc            <= `AAC_ACC_RESET;
      sample_strobe  <= 1'b0;
    end else begin
      sample_strobe <= 1'b0;
      case (state)
        ST_IDLE: begin
          // setup is frozen at start so a run keeps one timing
          if (conv_start) begin
            state          <= ST_OVH_CONVERSION_CLOCK;
            phase_cnt      <= 6'h00;
            cfg_per_conv   <= base_time + long_adder(long_sample_enable, long_sample_select) + hs_time;
            conv_left      <= factor;
            cfg_shift      <= avg_shift(average_enable, average_count_select);
            cfg_mode_10bit <= mode_10bit;
            cfg_ovh_conversion_clock   <= first_overhead(long_sample_enable);
            acc            <= `AAC_ACC_RESET;
          end
        end
        ST_OVH_CONVERSION_CLOCK: begin
          if (conversion_clock_tick) begin
            if (phase_cnt == cfg_ovh_conversion_clock - 6'h01) begin
              state     <= ST_OVH_BUS;
              phase_cnt <= 6'h00;
            end else begin
              phase_cnt <= phase_cnt + 6'h01;
            end
          end
        end
        ST_OVH_BUS: begin
          if (phase_cnt == `AAC_OVH_BUS - 6'h01) begin
            state     <= ST_CONVERT;
            phase_cnt <= 6'h00;
          end else begin
            phase_cnt <= phase_cnt + 6'h01;
          end
        end
        ST_CONVERT: begin
          if (conversion_clock_tick) begin
            if (phase_cnt == cfg_per_conv - 6'h01) begin
              acc           <= acc + {5'h00, sample_in};
              sample_strobe <= 1'b1;
              phase_cnt     <= 6'h00;
              conv_left     <= conv_left - 6'h01;
              // no flag until the last conversion
              if (conv_left == 6'h01) begin
                state <= ST_FINISH;
              end
            end else begin
              phase_cnt <= phase_cnt + 6'h01;
            end
          end
        end
        ST_FINISH: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // active from start until the finish cycle ends
  assign next_active = (state == ST_IDLE) ? conv_start : (state != ST_FINISH);

  // run status
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      conversion_active_flag <= 1'b0;
    end else begin
      conversion_active_flag <= next_active;
    end
  end

  // completion flag and result, both land on the edge that ends the run
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      conversion_complete_flag <= 1'b0;
      result_register          <= `AAC_RESULT_RESET;
    end else begin
      conversion_complete_flag <= next_complete;
      // false compare leaves the result untouched
      if (post_result) begin
        result_register <= avg_value;
      end
    end
  end

  // levels, not pulses, so software that polls late still sees the request
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_request  <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      irq_request  <= next_complete & complete_irq_enable;
      wake_request <= next_complete & complete_irq_enable & mcu_low_power;
    end
  end

endmodule // aac_average_compare

`default_nettype wire

// ---- aac_core_model.sv ----
/*
  Converter core stand-in: serves one stored sample word per conversion.
  Assumes the testbench loads mem before each run.
*/
`timescale 1ns/10ps
`default_nettype none
module aac_core_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // run control seen from the block
  input  wire logic       conv_start,
  input  wire logic       conversion_active_flag,
  input  wire logic       sample_strobe,
  // sample word
  output var  logic [9:0] sample_value
);
  logic [9:0] mem [0:31];
  logic [4:0] idx;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) idx <= 5'h00;
    else if (conv_start && !conversion_active_flag) idx <= 5'h00;
    else if (sample_strobe) idx <= idx + 5'h01;
  end
  // advance only after the strobe so a word holds through its whole conversion
  assign sample_value = mem[idx];
endmodule // aac_core_model
`default_nettype wire

// ---- aac_average_compare_props.sv ----
/*
  Checker for the averaging and compare block, bound to its ports.
  Assumes one clock domain and the reset of that domain.
*/
`timescale 1ns/10ps
`default_nettype none
module aac_average_compare_props (
  // clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // watched inputs
  input wire logic       conv_start,
  input wire logic       compare_enable,
  input wire logic       complete_irq_enable,
  input wire logic       complete_flag_clear,
  input wire logic       mcu_low_power,
  // watched outputs
  input wire logic       conversion_active_flag,
  input wire logic       conversion_complete_flag,
  input wire logic [9:0] result_register,
  input wire logic       sample_strobe,
  input wire logic       irq_request,
  input wire logic       wake_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [11:0] run_len;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) run_len <= 12'h000;
    else if (!conversion_active_flag) run_len <= 12'h000;
    else if (run_len != 12'hFFF) run_len <= run_len + 12'h001;
  end
  sequence s_take; conv_start && !conversion_active_flag; endsequence
  sequence s_post; $fell(conversion_active_flag); endsequence
  chk_active_hold: assert property (s_take |=> conversion_active_flag [*8])
    else $error("active flag dropped early");
  chk_run_length: assert property (s_post |-> run_len >= 12'd40 && run_len <= 12'd2720)
    else $error("run length out of bounds");
  chk_flag_at_end: assert property ($rose(conversion_complete_flag) |-> s_post)
    else $error("complete flag set inside a run");
  chk_result_hold: assert property (!$fell(conversion_active_flag) |-> $stable(result_register))
    else $error("result changed outside a post");
  chk_compare_off: assert property (!$past(compare_enable) ##0 s_post |-> conversion_complete_flag)
    else $error("result not posted with compare off");
  chk_irq_raise: assert property (
    $rose(conversion_complete_flag) && complete_irq_enable && $past(complete_irq_enable) |-> irq_request)
    else $error("irq missing on complete");
  chk_irq_quiet: assert property (!complete_irq_enable && !$past(complete_irq_enable) |-> !irq_request)
    else $error("irq while disabled");
  chk_wake_cause: assert property (wake_request |-> irq_request && $past(mcu_low_power))
    else $error("wake without cause");
  chk_wake_raise: assert property ($rose(irq_request) && $past(mcu_low_power) |-> wake_request)
    else $error("wake missing in low power");
  chk_flag_clear: assert property (
    $past(complete_flag_clear) && !$fell(conversion_active_flag) |-> !conversion_complete_flag)
    else $error("complete flag not cleared");
  chk_strobe_run: assert property (sample_strobe |-> conversion_active_flag || $past(conversion_active_flag))
    else $error("sample strobe outside a run");
endmodule // aac_average_compare_props
bind aac_average_compare aac_average_compare_props u_props (.clk, .sys_rst, .conv_start, .compare_enable,
  .complete_irq_enable, .complete_flag_clear, .mcu_low_power, .conversion_active_flag,
  .conversion_complete_flag, .result_register, .sample_strobe, .irq_request, .wake_request);
`default_nettype wire

// ---- aac_tb.sv ----
/*
  Self-checking testbench for the averaging and compare block.
  Assumes the core stand-in model and the bound checker are compiled.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 0, sys_rst = 1, conv_start = 0, mode_10bit = 0, long_sample_enable = 0, high_speed_config = 0;
  logic average_enable = 0, compare_enable = 0, compare_greater_select = 0, compare_range_enable = 0;
  logic complete_irq_enable = 0, complete_flag_clear = 0, mcu_low_power = 0;
  logic [1:0] long_sample_select = 2'h0, average_count_select = 2'h0;
  logic [9:0] first_compare_value = 10'h000, second_compare_value = 10'h000, sample_value, result_register;
  logic conversion_active_flag, conversion_complete_flag, sample_strobe, irq_request, wake_request;
  int seed = 2957, failures = 0, comparisons = 0;
  always #5 clk = ~clk;
  aac_average_compare dut (.clk, .sys_rst, .conv_start, .mode_10bit, .long_sample_enable, .long_sample_select,
    .high_speed_config, .average_enable, .average_count_select, .compare_enable, .compare_greater_select,
    .compare_range_enable, .first_compare_value, .second_compare_value, .complete_irq_enable,
    .complete_flag_clear, .mcu_low_power, .sample_value, .conversion_active_flag, .conversion_complete_flag,
    .result_register, .sample_strobe, .irq_request, .wake_request);
  aac_core_model core (.clk, .sys_rst, .conv_start, .conversion_active_flag, .sample_strobe, .sample_value);
  function automatic logic judge(input logic [9:0] v, c1, c2, input logic gt, rg);
    if (!rg) return gt ? v >= c1 : v < c1;
    if (!gt) return c1 <= c2 ? (v < c1 || v > c2) : (v < c1 && v > c2);
    return c1 <= c2 ? (v >= c1 && v <= c2) : (v >= c1 || v <= c2);
  endfunction
  task chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic run(input logic av, input logic [1:0] sel, input logic ce, gt, rg, input logic [9:0] c1, c2,
                     input logic fx, input logic [9:0] v);
    int n, sum, cyc, st, per, expc;
    logic [9:0] avg, old, mask;
    logic post, early;
    n = av ? 4 << sel : 1;
    @(posedge clk); #1;
    mode_10bit = fx | $random(seed);
    long_sample_enable = $random(seed);
    long_sample_select = $random(seed);
    high_speed_config = $random(seed);
    complete_irq_enable = $random(seed);
    mcu_low_power = $random(seed);
    {average_enable, average_count_select, compare_enable} = {av, sel, ce};
    {compare_greater_select, compare_range_enable, first_compare_value, second_compare_value} = {gt, rg, c1, c2};
    foreach (core.mem[i]) core.mem[i] = fx ? v : 10'($random(seed));
    complete_flag_clear = 1;
    @(posedge clk); #1;
    complete_flag_clear = 0;
    conv_start = 1;
    old = result_register;
    cyc = 0; st = 0; early = 0;
    do begin
      @(posedge clk); #1;
      cyc++;
      conv_start = (cyc == 20);
      st += sample_strobe;
      if (conversion_active_flag === 1'b1) early |= conversion_complete_flag;
    end while (conversion_active_flag === 1'b1 && cyc < 3000);
    mask = mode_10bit ? 10'h3FF : 10'h0FF;
    sum = 0;
    for (int i = 0; i < n; i++) sum += core.mem[i] & mask;
    avg = 10'(sum >> (av ? sel + 2 : 0));
    post = !ce || judge(avg, c1, c2, gt, rg);
    per = (mode_10bit ? 20 : 17) + (high_speed_config ? 2 : 0);
    if (long_sample_enable) per += long_sample_select == 0 ? 20 : long_sample_select == 1 ? 12 :
                                   long_sample_select == 2 ? 6 : 2;
    expc = 2 * (long_sample_enable ? 3 : 5) + 5 + 2 * n * per;
    chk(result_register, post ? avg : old);
    chk(conversion_complete_flag, post);
    chk(irq_request, post & complete_irq_enable);
    chk(wake_request, post & complete_irq_enable & mcu_low_power);
    chk(st, n);
    chk(early, 0);
    // free-running divider phase adds at most one cycle
    chk(cyc >= expc && cyc <= expc + 1, 1);
    $display("run done: factor %0d compare %0d posted %0d cycles %0d", n, ce, post, cyc);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 sys_rst = 0;
    for (int a = 0; a < 5; a++) run(a != 0, 2'(a - 1), 0, 0, 0, 10'h000, 10'h000, 0, 10'h000);
    // endpoint values for every compare mode, both threshold orders
    for (int k = 0; k < 16; k++) run(0, 0, 1, k[0], k[1], k[2] ? 10'h200 : 10'h100, k[2] ? 10'h100 : 10'h200,
                                     1, k[3] ? 10'h200 : 10'h100);
    for (int r = 0; r < 14; r++) run($random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
                                     $random(seed), $random(seed), 0, 10'h000);
    summarize;
  end
  initial begin
    // the longest legal mix of runs ends near 45,000 cycles; only a hang gets here
    #500000;
    failures++;
    summarize;
  end
endmodule // tb
`default_nettype wire
